// [acg_codec_clk.sv]
// codec end: audio port clock generator with its control registers
// ---------------------------------------------------------------
// How it works
// - master drives clock pins while converters run
// - slave keeps clock pin drivers off
// - bit 7 of reg 43 shares frame clock
// - shared source bit picks dac/adc; keep 0
// - reg 43 offset enable, master clock block
// - reg 43 bits 3/2 power down dlls
// - reg 0 bit 7 restores register defaults
// - gating bit chooses when frame clocks stop
// - common rate bit and chip clock source
// - sequencer enable and reference enable bits
// - adc ratio reg 0x0d, dac 0x18
// - ratio bit 5 selects double speed
// - five-bit code maps to frame ratio
// - slave checks ratio against codes 0 to 12
// - master divides master clock by ratio
// - reg 8 bit 7 selects port role
// - reg 8 halves master clock, inverts bclk
// - bit divider code table, zero is automatic
// - slave measures bit clock ratio automatically
// - software picks enough bit clocks per frame
// - four msb-first formats, regs 12 and 23
// - format field encodings
// - word length field encodings
// ---------------------------------------------------------------
`default_nettype none
`include "acg_params.svh"
module acg_codec_clk (
   input  wire logic      hclk,
   input  wire logic      hresetn,
   acg_link_if.dev        link,
   input  wire logic [1:0] adc_en,
   input  wire logic [1:0] dac_en,
   output logic           offset_en,
   output logic           adc_dll_pd,
   output logic           dac_dll_pd,
   output logic           seq_en,
   output logic           ref_en,
   output logic           common_rate,
   output logic           clk_src_dac,
   output logic [1:0]     adc_frame_format,
   output logic [1:0]     dac_frame_format,
   output logic [2:0]     adc_word_length,
   output logic [2:0]     dac_word_length,
   output logic           ratio_ok,
   output logic [11:0]    ratio_meas,
   output logic [7:0]     bclk_meas
);
   import acg_pkg::*;
   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   acg_byte_t chip_ctl_r, role_div_r, adc_fmt_r, dac_fmt_r;
   acg_byte_t adc_ratio_r, dac_ratio_r, frame_dll_r;
   logic      wr_soft;

   assign wr_soft = link.reg_wr && link.reg_addr == `ACG_CHIP_CTL &&
                    link.reg_wdata[`ACG_B_SOFT_RST];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chip_ctl_r  <= `ACG_CHIP_CTL_RST;
         role_div_r  <= `ACG_ROLE_DIV_RST;
         adc_fmt_r   <= `ACG_FMT_RST;
         dac_fmt_r   <= `ACG_FMT_RST;
         adc_ratio_r <= `ACG_RATIO_RST;
         dac_ratio_r <= `ACG_RATIO_RST;
         frame_dll_r <= `ACG_FRAME_DLL_RST;
      end else if (wr_soft) begin
         chip_ctl_r  <= `ACG_CHIP_CTL_RST;
         role_div_r  <= `ACG_ROLE_DIV_RST;
         adc_fmt_r   <= `ACG_FMT_RST;
         dac_fmt_r   <= `ACG_FMT_RST;
         adc_ratio_r <= `ACG_RATIO_RST;
         dac_ratio_r <= `ACG_RATIO_RST;
         frame_dll_r <= `ACG_FRAME_DLL_RST;
      end else if (link.reg_wr) begin
         case (link.reg_addr)
            `ACG_CHIP_CTL:  chip_ctl_r  <= link.reg_wdata & 8'h7f;
            `ACG_ROLE_DIV:  role_div_r  <= link.reg_wdata;
            `ACG_ADC_FMT:   adc_fmt_r   <= link.reg_wdata;
            `ACG_DAC_FMT:   dac_fmt_r   <= link.reg_wdata;
            `ACG_ADC_RATIO: adc_ratio_r <= link.reg_wdata;
            `ACG_DAC_RATIO: dac_ratio_r <= link.reg_wdata;
            `ACG_FRAME_DLL: frame_dll_r <= link.reg_wdata;
            default: ;
         endcase
      end
   end

   // reads answer one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.reg_ack   <= 1'b0;
         link.reg_rdata <= 8'h00;
      end else begin
         link.reg_ack <= link.reg_wr | link.reg_rd;
         if (link.reg_rd) begin
            case (link.reg_addr)
               `ACG_CHIP_CTL:  link.reg_rdata <= chip_ctl_r;
               `ACG_ROLE_DIV:  link.reg_rdata <= role_div_r;
               `ACG_ADC_FMT:   link.reg_rdata <= adc_fmt_r;
               `ACG_DAC_FMT:   link.reg_rdata <= dac_fmt_r;
               `ACG_ADC_RATIO: link.reg_rdata <= adc_ratio_r;
               `ACG_DAC_RATIO: link.reg_rdata <= dac_ratio_r;
               `ACG_FRAME_DLL: link.reg_rdata <= frame_dll_r;
               default:        link.reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // configuration outputs
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         offset_en        <= 1'b0;
         adc_dll_pd       <= 1'b0;
         dac_dll_pd       <= 1'b0;
         seq_en           <= 1'b0;
         ref_en           <= 1'b0;
         common_rate      <= 1'b0;
         clk_src_dac      <= 1'b0;
         adc_frame_format <= 2'h0;
         dac_frame_format <= 2'h0;
         adc_word_length  <= 3'h0;
         dac_word_length  <= 3'h0;
      end else begin
         offset_en   <= frame_dll_r[`ACG_B_OFFSET];
         adc_dll_pd  <= frame_dll_r[`ACG_B_ADC_DLL];
         dac_dll_pd  <= frame_dll_r[`ACG_B_DAC_DLL];
         seq_en      <= chip_ctl_r[`ACG_B_SEQ_EN];
         ref_en      <= chip_ctl_r[`ACG_B_REF_EN];
         common_rate <= chip_ctl_r[`ACG_B_SAME_FS];
         // source select only means something at a common rate
         clk_src_dac <= chip_ctl_r[`ACG_B_SAME_FS] &
                        chip_ctl_r[`ACG_B_SRC_SEL];
         adc_frame_format <= adc_fmt_r[1:0];
         dac_frame_format <= dac_fmt_r[2:1];
         adc_word_length  <= adc_fmt_r[4:2];
         dac_word_length  <= dac_fmt_r[5:3];
      end
   end

   // ------------------------------------------------------------
   // master mode clock generation
   // ------------------------------------------------------------
   logic        master, adc_act, dac_act, use_adc, run, tick, half_r;
   logic [7:0]  sel_ratio;
   logic [11:0] ratio, fr_cnt_r;
   logic [6:0]  bdiv, bit_cnt_r;

   assign master  = role_div_r[`ACG_B_ROLE];
   assign adc_act = |adc_en;
   assign dac_act = |dac_en;
   // the pin carries one frame clock; when shared the source bit picks it, else the dac if active
   assign use_adc = frame_dll_r[`ACG_B_SHARED] ?
                    frame_dll_r[`ACG_B_FSRC] : !dac_act;
   assign sel_ratio = use_adc ? adc_ratio_r : dac_ratio_r;
   assign ratio = sel_ratio[`ACG_B_DOUBLE] ?
                  (ratio_of(sel_ratio[4:0]) >> 1) :
                  ratio_of(sel_ratio[4:0]);
   assign run = (chip_ctl_r[`ACG_B_GATING] ? (adc_act | dac_act) :
                 (use_adc ? adc_act : dac_act)) &&
                ratio != 12'd0;
   assign bdiv = div_of(role_div_r[4:0], ratio);
   // a blocked master clock pad stops every tick
   assign tick = !frame_dll_r[`ACG_B_MCLK_DIS] &&
                 (!role_div_r[`ACG_B_HALVE] || half_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_r <= 1'b0;
      end else begin
         half_r <= !half_r;
      end
   end

   // bit counter restarts with each frame so edges stay aligned
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fr_cnt_r  <= 12'd0;
         bit_cnt_r <= 7'd0;
      end else if (!master || !run) begin
         fr_cnt_r  <= 12'd0;
         bit_cnt_r <= 7'd0;
      end else if (tick) begin
         if (fr_cnt_r >= ratio - 12'd1) begin
            fr_cnt_r  <= 12'd0;
            bit_cnt_r <= 7'd0;
         end else begin
            fr_cnt_r  <= fr_cnt_r + 12'd1;
            bit_cnt_r <= (bit_cnt_r >= bdiv - 7'd1) ? 7'd0 :
                         bit_cnt_r + 7'd1;
         end
      end
   end

   // divide by one cannot be made from this clock; such a bclk stays low, or high when inverted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.dev_bclk_o  <= 1'b0;
         link.dev_fclk_o  <= 1'b0;
         link.dev_bclk_oe <= 1'b0;
         link.dev_fclk_oe <= 1'b0;
      end else begin
         link.dev_bclk_oe <= master && run;
         link.dev_fclk_oe <= master && run;
         link.dev_fclk_o  <= fr_cnt_r < (ratio >> 1);
         link.dev_bclk_o  <= (bit_cnt_r < (bdiv >> 1)) ^
                             role_div_r[`ACG_B_BIT_CLOCK_INVERT];
      end
   end

   // ------------------------------------------------------------
   // slave mode ratio check
   // ------------------------------------------------------------
   logic [2:0]  fsync_r, bsync_r;
   logic [11:0] fper_r;
   logic [7:0]  bper_r;
   logic        f_rise, b_rise, ok;

   assign f_rise = fsync_r[1] & !fsync_r[2];
   assign b_rise = bsync_r[1] & !bsync_r[2];

   always_comb begin
      ok = 1'b0;
      for (int i = 0; i <= 12; i++) begin
         if (fper_r + 12'd1 == ratio_of(5'(i))) begin
            ok = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fsync_r    <= 3'h0;
         bsync_r    <= 3'h0;
         fper_r     <= 12'd0;
         bper_r     <= 8'd0;
         ratio_ok   <= 1'b0;
         ratio_meas <= 12'd0;
         bclk_meas  <= 8'd0;
      end else begin
         fsync_r <= {fsync_r[1:0], link.fclk_line};
         bsync_r <= {bsync_r[1:0], link.bclk_line};
         if (f_rise) begin
            fper_r <= 12'd0;
            if (!master) begin
               ratio_meas <= fper_r + 12'd1;
               ratio_ok   <= ok;
            end
         end else if (fper_r != 12'hfff) begin
            fper_r <= fper_r + 12'd1;
         end
         if (b_rise) begin
            bper_r <= 8'd0;
            if (!master) begin
               bclk_meas <= bper_r + 8'd1;
            end
         end else if (bper_r != 8'hff) begin
            bper_r <= bper_r + 8'd1;
         end
      end
   end
endmodule
`default_nettype wire

// [acg_host_port.sv]
// controller end: ahb-lite registers, register link master, slave clocks
`default_nettype none
`include "acg_params.svh"
module acg_host_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   acg_link_if.host         link
);
   import acg_pkg::*;
   // ------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ------------------------------------------------------------
   logic      wr_pend_r;
   acg_byte_t wr_addr_r, bdiv_r, flen_r, rdat_r;
   logic      drive_r, busy, take, cmd_go;
   acg_cmd_e  st_r;

   assign take   = hsel && hready && htrans[1];
   assign busy   = st_r == ACG_ST_WAIT;
   assign cmd_go = wr_pend_r && wr_addr_r == `ACG_H_CMD && !busy;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata    <= 32'h0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         wr_pend_r <= take && hwrite;
         wr_addr_r <= haddr[7:0];
         if (take && !hwrite) begin
            case (haddr[7:0])
               `ACG_H_STAT: hrdata <= {16'h0, rdat_r, 7'h0, busy};
               `ACG_H_BDIV: hrdata <= {24'h0, bdiv_r};
               `ACG_H_FLEN: hrdata <= {23'h0, drive_r, flen_r};
               default:     hrdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bdiv_r  <= `ACG_H_BDIV_RST;
         flen_r  <= `ACG_H_FLEN_RST;
         drive_r <= 1'b0;
      end else if (wr_pend_r && wr_addr_r == `ACG_H_BDIV) begin
         bdiv_r <= hwdata[7:0];
      end else if (wr_pend_r && wr_addr_r == `ACG_H_FLEN) begin
         flen_r  <= hwdata[7:0];
         drive_r <= hwdata[8];
      end
   end

   // ------------------------------------------------------------
   // register link command: one strobe, wait for the answer
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r           <= ACG_ST_IDLE;
         link.reg_wr    <= 1'b0;
         link.reg_rd    <= 1'b0;
         link.reg_addr  <= 8'h00;
         link.reg_wdata <= 8'h00;
         rdat_r         <= 8'h00;
      end else begin
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         unique case (st_r)
            ACG_ST_IDLE: begin
               if (cmd_go) begin
                  link.reg_addr  <= hwdata[15:8];
                  link.reg_wdata <= hwdata[7:0];
                  link.reg_wr    <= !hwdata[16];
                  link.reg_rd    <= hwdata[16];
                  st_r           <= ACG_ST_WAIT;
               end
            end
            ACG_ST_WAIT: begin
               if (link.reg_ack) begin
                  rdat_r <= link.reg_rdata;
                  st_r   <= ACG_ST_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // clock drive for a codec in slave role
   // ------------------------------------------------------------
   logic [7:0] bc_r, bits_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bc_r              <= 8'h00;
         bits_r            <= 8'h00;
         link.host_bclk_o  <= 1'b0;
         link.host_fclk_o  <= 1'b0;
         link.host_bclk_oe <= 1'b0;
         link.host_fclk_oe <= 1'b0;
      end else begin
         link.host_bclk_oe <= drive_r;
         link.host_fclk_oe <= drive_r;
         if (!drive_r) begin
            bc_r             <= 8'h00;
            bits_r           <= 8'h00;
            link.host_bclk_o <= 1'b0;
            link.host_fclk_o <= 1'b0;
         end else if (bc_r >= (bdiv_r >> 1) - 8'd1) begin
            bc_r             <= 8'h00;
            link.host_bclk_o <= !link.host_bclk_o;
            if (link.host_bclk_o) begin
               bits_r <= (bits_r >= flen_r - 8'd1) ? 8'h00 :
                         bits_r + 8'd1;
               link.host_fclk_o <= bits_r < (flen_r >> 1);
            end
         end else begin
            bc_r <= bc_r + 8'd1;
         end
      end
   end
endmodule
`default_nettype wire

// [acg_link_if.sv]
// link between controller and codec: register port and clock pins
`default_nettype none
interface acg_link_if (input wire logic hclk);
   import acg_pkg::*;
   logic      reg_wr;
   logic      reg_rd;
   acg_byte_t reg_addr;
   acg_byte_t reg_wdata;
   acg_byte_t reg_rdata;
   logic      reg_ack;
   logic      dev_bclk_o;
   logic      dev_bclk_oe;
   logic      dev_fclk_o;
   logic      dev_fclk_oe;
   logic      host_bclk_o;
   logic      host_bclk_oe;
   logic      host_fclk_o;
   logic      host_fclk_oe;
   logic      bclk_line;
   logic      fclk_line;
   // weak pull-down when nobody drives
   assign bclk_line = dev_bclk_oe ? dev_bclk_o :
                      (host_bclk_oe & host_bclk_o);
   assign fclk_line = dev_fclk_oe ? dev_fclk_o :
                      (host_fclk_oe & host_fclk_o);
   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, reg_ack,
                output dev_bclk_o, dev_bclk_oe, dev_fclk_o, dev_fclk_oe,
                input bclk_line, fclk_line);
   modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                 input reg_rdata, reg_ack,
                 output host_bclk_o, host_bclk_oe,
                 output host_fclk_o, host_fclk_oe,
                 input bclk_line, fclk_line);
endinterface
`default_nettype wire

// [acg_link_sva.sv]
// checker for the controller-to-codec link and clock pins
`default_nettype none
module acg_link_sva
   import acg_pkg::*;
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire acg_pkg::acg_byte_t reg_addr,
   input wire acg_pkg::acg_byte_t reg_rdata,
   input wire logic              reg_ack,
   input wire logic              dev_bclk_o,
   input wire logic              dev_bclk_oe,
   input wire logic              dev_fclk_o,
   input wire logic              dev_fclk_oe,
   input wire logic              host_fclk_oe
);
   // --------------------
   // link properties
   // --------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
   a_ack: assert property (p_ack)
      else $error("link strobe not acknowledged");
   property p_ack_src; reg_ack |-> $past(reg_wr || reg_rd); endproperty
   a_ack_src: assert property (p_ack_src)
      else $error("link ack without strobe");
   property p_rdata_src;
      $changed(reg_rdata) |-> reg_ack && $past(reg_rd);
   endproperty
   a_rdata_src: assert property (p_rdata_src)
      else $error("read data moved without a read");
   property p_unmapped; reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_oe_pair; dev_bclk_oe == dev_fclk_oe; endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("clock pin drivers disagree");
   property p_align; $rose(dev_fclk_o) && dev_fclk_oe |-> dev_bclk_o;
   endproperty
   a_align: assert property (p_align)
      else $error("frame edge not on bit clock start");
   property p_bclk_runs;
      $rose(dev_fclk_o) && dev_fclk_oe |->
         ##[1:200] ($fell(dev_bclk_o) || !dev_fclk_oe);
   endproperty
   a_bclk_runs: assert property (p_bclk_runs)
      else $error("bit clock stalled in frame");
   property p_no_fight; !(dev_fclk_oe && host_fclk_oe); endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive frame clock");
endmodule
`default_nettype wire

// [acg_params.svh]
// constants shared by the audio port clock generator and its controller
`ifndef ACG_PARAMS_SVH
`define ACG_PARAMS_SVH
// ---------------------------------------------------------------
// device register offsets and reset values
// ---------------------------------------------------------------
`define ACG_CHIP_CTL      8'h00
`define ACG_ROLE_DIV      8'h08
`define ACG_ADC_FMT       8'h0c
`define ACG_ADC_RATIO     8'h0d
`define ACG_DAC_FMT       8'h17
`define ACG_DAC_RATIO     8'h18
`define ACG_FRAME_DLL     8'h2b
`define ACG_CHIP_CTL_RST  8'h06
`define ACG_ROLE_DIV_RST  8'h80
`define ACG_RATIO_RST     8'h06
`define ACG_FMT_RST       8'h00
`define ACG_FRAME_DLL_RST 8'h38
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACG_B_SOFT_RST    7
`define ACG_B_GATING      6
`define ACG_B_SRC_SEL     5
`define ACG_B_SAME_FS     4
`define ACG_B_SEQ_EN      3
`define ACG_B_REF_EN      2
`define ACG_B_ROLE        7
`define ACG_B_HALVE       6
`define ACG_B_BIT_CLOCK_INVERT    5
`define ACG_B_DOUBLE      5
`define ACG_B_SHARED      7
`define ACG_B_FSRC        6
`define ACG_B_OFFSET      5
`define ACG_B_MCLK_DIS    4
`define ACG_B_ADC_DLL     3
`define ACG_B_DAC_DLL     2
`define ACG_AUTO_BITS     12'd64
// ---------------------------------------------------------------
// controller AHB-Lite register offsets
// ---------------------------------------------------------------
`define ACG_H_CMD         8'h00
`define ACG_H_STAT        8'h04
`define ACG_H_BDIV        8'h08
`define ACG_H_FLEN        8'h0c
`define ACG_H_BDIV_RST    8'h04
`define ACG_H_FLEN_RST    8'h40
`endif

// [acg_pkg.sv]
// types and code tables shared by the clock generator and its controller
`default_nettype none
`include "acg_params.svh"
package acg_pkg;
   typedef logic [7:0] acg_byte_t;
   typedef enum logic {ACG_ST_IDLE, ACG_ST_WAIT} acg_cmd_e;
   // frame ratio per code; zero marks a reserved code
   localparam logic [11:0] ACG_RATIO_TAB [32] = '{
      12'd128, 12'd192, 12'd256, 12'd384, 12'd512, 12'd576, 12'd768,
      12'd1024, 12'd1152, 12'd1408, 12'd1536, 12'd2112, 12'd2304,
      12'd0, 12'd0, 12'd0, 12'd125, 12'd136, 12'd250, 12'd272,
      12'd375, 12'd500, 12'd544, 12'd750, 12'd1000, 12'd1088,
      12'd1496, 12'd1500, 12'd0, 12'd0, 12'd0, 12'd0};
   // bit clock divisor per code; codes past the table divide by four
   localparam logic [6:0] ACG_DIV_TAB [32] = '{
      7'd0, 7'd1, 7'd2, 7'd3, 7'd4, 7'd6, 7'd8, 7'd9,
      7'd11, 7'd12, 7'd16, 7'd18, 7'd22, 7'd24, 7'd33, 7'd36,
      7'd44, 7'd48, 7'd66, 7'd72, 7'd5, 7'd10, 7'd15, 7'd17,
      7'd20, 7'd25, 7'd30, 7'd32, 7'd34, 7'd4, 7'd4, 7'd4};

   function automatic logic [11:0] ratio_of(input logic [4:0] c);
      return ACG_RATIO_TAB[c];
   endfunction

   // code zero derives the divisor from the frame ratio, at least one
   function automatic logic [6:0] div_of(input logic [4:0]  c,
                                         input logic [11:0] r);
      logic [11:0] q;
      q = r / `ACG_AUTO_BITS;
      if (c != 5'h00) begin
         return ACG_DIV_TAB[c];
      end
      return (q == 12'd0) ? 7'd1 : q[6:0];
   endfunction
endpackage
`default_nettype wire

// [tb_top.sv]
// self-checking bench: controller and codec joined over the link
`default_nettype none
module tb_top
   import acg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, n;
   logic [1:0]  htrans = '0, adc_en = '0, dac_en = '0, af, df;
   logic        hreadyout, hresp, ofs, dla, dld, seq, rf, cmr, src, ok;
   logic [2:0]  aw, dw;
   logic [11:0] rm;
   logic [7:0]  bm;
   logic [7:0]  ra [5] = '{8'h00, 8'h08, 8'h0d, 8'h18, 8'h2b};
   logic [7:0]  re [5] = '{8'h06, 8'h80, 8'h06, 8'h06, 8'h38};
   int          num_errors = 0, total_checks = 0;
   always #10 hclk = ~hclk;
   acg_link_if lk (.hclk(hclk));
   acg_codec_clk acg_codec_clk_i (.hclk(hclk), .hresetn(hresetn),
      .link(lk.dev), .adc_en(adc_en), .dac_en(dac_en), .offset_en(ofs),
      .adc_dll_pd(dla), .dac_dll_pd(dld), .seq_en(seq), .ref_en(rf),
      .common_rate(cmr), .clk_src_dac(src), .adc_frame_format(af),
      .dac_frame_format(df), .adc_word_length(aw), .dac_word_length(dw),
      .ratio_ok(ok), .ratio_meas(rm), .bclk_meas(bm));
   acg_host_port acg_host_port_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link(lk.host));
   acg_link_sva acg_link_sva_i (.hclk(hclk), .hresetn(hresetn),
      .reg_wr(lk.reg_wr), .reg_rd(lk.reg_rd), .reg_addr(lk.reg_addr),
      .reg_rdata(lk.reg_rdata), .reg_ack(lk.reg_ack),
      .dev_bclk_o(lk.dev_bclk_o), .dev_bclk_oe(lk.dev_bclk_oe),
      .dev_fclk_o(lk.dev_fclk_o), .dev_fclk_oe(lk.dev_fclk_oe),
      .host_fclk_oe(lk.host_fclk_oe));
   // --------------------
   // bus tasks
   // --------------------
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // busy clears two edges after the command data phase; wait three, then poll
   task automatic wt;
      repeat (3) @(posedge hclk);
      do ahb(1'b0, 8'h04, '0, q); while (q[0] !== 1'b0);
   endtask
   task automatic cw(input logic [7:0] a, d);
      ahb(1'b1, 8'h00, {16'h0, a, d}, q);
      wt();
   endtask
   task automatic cr(input logic [7:0] a, output logic [31:0] r);
      ahb(1'b1, 8'h00, {15'h0, 1'b1, a, 8'h00}, q);
      wt();
      r = {24'h0, q[15:8]};
   endtask
   function automatic logic ln(input logic f);
      return f ? lk.fclk_line : lk.bclk_line;
   endfunction
   // first period after a change may be partial, so measure the second
   task automatic per(input logic f, output logic [31:0] p);
      repeat (2) begin
         while (ln(f)) @(posedge hclk);
         while (!ln(f)) @(posedge hclk);
         p = 0;
         while (ln(f)) begin @(posedge hclk); p++; end
         while (!ln(f)) begin @(posedge hclk); p++; end
      end
   endtask
   // --------------------
   // scenarios
   // --------------------
   initial begin
      repeat (60000) @(posedge hclk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 5; i++) begin
         cr(ra[i], q);
         chk(q, re[i]);
      end
      chk(rf, 1'b1);
      cw(8'h2b, 8'h2c);
      cw(8'h00, 8'h3c);
      cw(8'h0c, 8'h0f);
      cw(8'h17, 8'h24);
      chk({ofs, dla, dld}, 3'b111);
      chk({src, cmr, seq, rf}, 4'hf);
      chk({af, aw, df, dw}, 10'b11_011_10_100);
      cr(8'h01, q);
      chk(q, 0);
      cw(8'h00, 8'h80);
      cr(8'h2b, q);
      chk(q, 8'h38);
      cr(8'h0c, q);
      chk(q, 0);
      cr(8'h00, q);
      chk(q, 8'h06);
      chk({ofs, dla, src}, 3'b110);
      cw(8'h2b, 8'h28);
      adc_en <= 2'b01;
      per(1'b1, n);
      chk(n, 768);
      chk(lk.dev_fclk_oe, 1'b1);
      per(1'b0, n);
      chk(n, 12);
      cw(8'h0d, 8'h26);
      per(1'b1, n);
      chk(n, 384);
      cw(8'h0d, 8'h12);
      cw(8'h08, 8'hd4);
      per(1'b1, n);
      chk(n, 500);
      per(1'b0, n);
      chk(n, 10);
      adc_en <= 2'b00;
      dac_en <= 2'b11;
      per(1'b1, n);
      chk(n, 1536);
      dac_en <= 2'b00;
      adc_en <= 2'b01;
      cw(8'h2b, 8'hb8);
      repeat (8) @(posedge hclk);
      chk(lk.dev_fclk_oe, 1'b0);
      cw(8'h00, 8'h46);
      repeat (8) @(posedge hclk);
      chk(lk.dev_fclk_oe, 1'b1);
      cw(8'h08, 8'h00);
      adc_en <= 2'b11;
      ahb(1'b1, 8'h08, 32'h4, q);
      ahb(1'b1, 8'h0c, 32'h140, q);
      repeat (1500) @(posedge hclk);
      chk(lk.dev_fclk_oe, 1'b0);
      chk({ok, rm, bm}, {1'b1, 12'd256, 8'd4});
      ahb(1'b1, 8'h0c, 32'h13b, q);
      repeat (1500) @(posedge hclk);
      chk({ok, rm}, {1'b0, 12'd236});
      end_sim();
   end
endmodule
`default_nettype wire
